//--- pkg/ppo_pkg.sv
// ppo_pkg: constants and carrier types of the port pin override logic
// assumes: included before every ppo_* module, used only by scoped names
package ppo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map on the plain register port
    localparam int unsigned ADDR_W = 3;
    localparam logic [2:0] REG_PIN_IN = 3'h0;
    localparam logic [2:0] REG_DIR = 3'h1;
    localparam logic [2:0] REG_OUT = 3'h2;
    localparam logic [2:0] REG_DRIVE_STATE = 3'h3;
    localparam logic [2:0] REG_PULL_STATE = 3'h4;
    localparam logic [2:0] REG_IN_ENABLE_STATE = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // reset values, one bit per pin
    localparam logic DIR_RST = 1'h0;
    localparam logic OUT_RST = 1'h0;
    localparam logic PIN_RST = 1'h0;
    localparam logic RDATA_RST = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // pull-up decode of {direction, output, global off}
    localparam logic [2:0] PULLUP_ON_CODE = 3'h2;

    ////////////////////////////////////////////////////////////////////////////
    // external interrupt sense modes
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } ppo_sense_e;

    // per-pin override set from the peripheral owning the pin
    typedef struct packed {
        logic pullup_ovr_en;
        logic pullup_ovr_val;
        logic dir_ovr_en;
        logic dir_ovr_val;
        logic value_ovr_en;
        logic value_ovr_val;
        logic toggle_ovr_en;
        logic in_enable_ovr_en;
        logic in_enable_ovr_val;
    } ppo_ovr_s;

    // per-pin external interrupt configuration
    typedef struct packed {
        logic irq_en;
        ppo_sense_e sense;
    } ppo_eint_s;

    // per-pin pad controls
    typedef struct packed {
        logic drive_val;
        logic drive_en;
        logic pullup_en;
        logic input_en;
    } ppo_pad_s;

    // per-pin analog path, passed straight to and from the pad
    typedef struct packed {
        logic out_val;
        logic out_en;
    } ppo_analog_s;

endpackage

//--- src/ppo_sync.sv
// ppo_sync: pin synchronizer, a latch open while the clock is high, then a flop
// assumes: d may change at any time; q is read only by logic on clock
`timescale 1ns/1ps
`default_nettype none
module ppo_sync (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // data
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic pin;
    } ppo_sync_state_s;

    logic lat;
    ppo_sync_state_s s_q;
    ppo_sync_state_s s_d;

    // transparent while clock is high, holds from the falling edge
    always_latch begin
        if (clock) begin
            lat <= d;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.pin = lat;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '{pin: ppo_pkg::PIN_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.pin;
endmodule
`default_nettype wire

//--- src/ppo_edge.sv
// ppo_edge: edge event of one synchronized pin for the external interrupt unit
// assumes: d is already synchronized to clock
`timescale 1ns/1ps
`default_nettype none
module ppo_edge (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pin and mode
    input wire logic d,
    input wire ppo_pkg::ppo_sense_e sense,
    // event
    output logic event_pulse
);
    typedef struct packed {
        logic prev;
    } ppo_edge_state_s;

    ppo_edge_state_s s_q;
    ppo_edge_state_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev = d;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '{prev: ppo_pkg::PIN_RST};
        end else begin
            s_q <= s_d;
        end
    end

    // enable is not looked at, so a clamp release still raises an event
    always_comb begin
        unique case (sense)
            ppo_pkg::SENSE_ANY: event_pulse = d ^ s_q.prev;
            ppo_pkg::SENSE_FALL: event_pulse = s_q.prev & ~d;
            ppo_pkg::SENSE_RISE: event_pulse = d & ~s_q.prev;
            ppo_pkg::SENSE_LOW: event_pulse = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

//--- src/ppo_port.sv
// ppo_port: one general-purpose port, direction/output/input registers per pin
// merged with the override signals of the peripherals owning alternate functions
// assumes: sleep, global_pullup_off and all override inputs come from logic on
// clock; pad_in comes from the pads and is asynchronous
`timescale 1ns/1ps
`default_nettype none
module ppo_port #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port, shared by all pins of the port
    input wire logic [ppo_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WIDTH-1:0] reg_rdata,
    // shared by all ports
    input wire logic sleep,
    input wire logic global_pullup_off,
    // per-pin overrides from alternate-function peripherals
    input wire ppo_pkg::ppo_ovr_s ovr [WIDTH],
    // per-pin external interrupt configuration
    input wire ppo_pkg::ppo_eint_s eint [WIDTH],
    // to and from alternate-function peripherals
    output logic [WIDTH-1:0] alt_digital_in,
    output logic [WIDTH-1:0] alt_analog_io_in,
    input wire ppo_pkg::ppo_analog_s alt_analog_io_out [WIDTH],
    // to the external interrupt unit
    output logic [WIDTH-1:0] ext_edge_event,
    // pads
    input wire logic [WIDTH-1:0] pad_in,
    output ppo_pkg::ppo_pad_s pad [WIDTH],
    output ppo_pkg::ppo_analog_s pad_analog [WIDTH]
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("ppo_port: WIDTH must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [WIDTH-1:0] pin_direction_bit;
        logic [WIDTH-1:0] pin_output_bit;
        logic [WIDTH-1:0] rdata;
    } ppo_port_state_s;

    ppo_port_state_s s_q;
    ppo_port_state_s s_d;

    logic [WIDTH-1:0] pin_input_bit;
    logic [WIDTH-1:0] in_enable;
    logic [WIDTH-1:0] clamped_in;
    logic [WIDTH-1:0] drive_en;
    logic [WIDTH-1:0] drive_val;
    logic [WIDTH-1:0] pullup_en;
    logic [WIDTH-1:0] toggle;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // pull-up decision of one pin
    function automatic logic pullup_of(
        input ppo_pkg::ppo_ovr_s o,
        input logic dir_bit,
        input logic out_bit,
        input logic off
    );
        logic r;
        if (o.pullup_ovr_en) begin
            r = o.pullup_ovr_val;
        end else begin
            r = ({dir_bit, out_bit, off} == ppo_pkg::PULLUP_ON_CODE);
        end
        return r;
    endfunction

    // digital input enable of one pin
    function automatic logic in_enable_of(
        input ppo_pkg::ppo_ovr_s o,
        input ppo_pkg::ppo_eint_s e,
        input logic slp
    );
        logic r;
        if (o.in_enable_ovr_en) begin
            r = o.in_enable_ovr_val;
        end else begin
            r = ~(slp & ~e.irq_en);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // per-pin input path, clamp, synchronizer and edge events

    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        // clamp to ground ahead of the Schmitt trigger
        assign in_enable[i] = in_enable_of(ovr[i], eint[i], sleep);
        assign clamped_in[i] = pad_in[i] & in_enable[i];

        // raw, unsynchronized; the peripheral synchronizes it
        assign alt_digital_in[i] = clamped_in[i];

        ppo_sync u_sync (
            .clock(clock),
            .rst(rst),
            .d(clamped_in[i]),
            .q(pin_input_bit[i])
        );

        ppo_edge u_edge (
            .clock(clock),
            .rst(rst),
            .d(pin_input_bit[i]),
            .sense(eint[i].sense),
            .event_pulse(ext_edge_event[i])
        );

        // analog path bypasses all digital gating, both directions
        assign alt_analog_io_in[i] = pad_in[i];
        assign pad_analog[i] = alt_analog_io_out[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin output path

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            // overrides are separate for each pin
            drive_en[i] = ovr[i].dir_ovr_en ? ovr[i].dir_ovr_val
                                            : s_q.pin_direction_bit[i];
            drive_val[i] = ovr[i].value_ovr_en ? ovr[i].value_ovr_val
                                               : s_q.pin_output_bit[i];
            pullup_en[i] = pullup_of(ovr[i], s_q.pin_direction_bit[i],
                                     s_q.pin_output_bit[i], global_pullup_off)
                           & ~rst;
        end
    end

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            pad[i].drive_val = drive_val[i];
            pad[i].drive_en = drive_en[i];
            pad[i].pullup_en = pullup_en[i];
            pad[i].input_en = in_enable[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // toggles from a register write of ones and from the peripheral override
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            toggle[i] = (reg_wr && reg_addr == ppo_pkg::REG_PIN_IN && reg_wdata[i])
                        | ovr[i].toggle_ovr_en;
        end
    end

    always_comb begin
        s_d = s_q;
        // strobes are shared by every pin of the port
        if (reg_wr && reg_addr == ppo_pkg::REG_DIR) begin
            s_d.pin_direction_bit = reg_wdata;
        end
        if (reg_wr && reg_addr == ppo_pkg::REG_OUT) begin
            s_d.pin_output_bit = reg_wdata;
        end
        // a toggle in the write cycle acts on the written value
        s_d.pin_output_bit = s_d.pin_output_bit ^ toggle;

        // read data stand only in the cycle after the read strobe
        s_d.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ppo_pkg::REG_PIN_IN: s_d.rdata = pin_input_bit;
                ppo_pkg::REG_DIR: s_d.rdata = s_q.pin_direction_bit;
                ppo_pkg::REG_OUT: s_d.rdata = s_q.pin_output_bit;
                ppo_pkg::REG_DRIVE_STATE: s_d.rdata = drive_en;
                ppo_pkg::REG_PULL_STATE: s_d.rdata = pullup_en;
                ppo_pkg::REG_IN_ENABLE_STATE: s_d.rdata = in_enable;
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '{pin_direction_bit: {WIDTH{ppo_pkg::DIR_RST}},
                     pin_output_bit: {WIDTH{ppo_pkg::OUT_RST}},
                     rdata: {WIDTH{ppo_pkg::RDATA_RST}}};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;

endmodule
`default_nettype wire

//--- dv/ppo_periph.sv
// ppo_periph: alternate-function peripheral beside ppo_port
// assumes: req and din come from bench logic on clock
`timescale 1ns/1ps
`default_nettype none
module ppo_periph #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // requests and raw pin input
    input wire ppo_pkg::ppo_ovr_s req [WIDTH],
    input wire logic [WIDTH-1:0] din,
    // to the port, and din_q to the bench
    output ppo_pkg::ppo_ovr_s ovr [WIDTH],
    output ppo_pkg::ppo_analog_s aout [WIDTH],
    output logic [WIDTH-1:0] din_q
);
    logic [WIDTH-1:0] s1_q;
    always_ff @(posedge clock or posedge rst) begin
        for (int i = 0; i < WIDTH; i++) begin
            ovr[i] <= rst ? '0 : req[i];
            aout[i] <= rst ? '0 : {req[i].value_ovr_val, 1'b0};
        end
        // own two-stage synchronizer on the raw input
        s1_q <= rst ? '0 : din;
        din_q <= rst ? '0 : s1_q;
    end
endmodule
`default_nettype wire

//--- dv/ppo_port_checker.sv
// ppo_port_checker: per-pin pad and override assertions
// assumes: bound into every ppo_port instance
`timescale 1ns/1ps
`default_nettype none
module ppo_port_checker #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // watched ports
    input wire logic reg_wr,
    input wire logic sleep,
    input wire logic global_pullup_off,
    input wire ppo_pkg::ppo_ovr_s ovr [WIDTH],
    input wire ppo_pkg::ppo_eint_s eint [WIDTH],
    input wire logic [WIDTH-1:0] alt_digital_in,
    input wire logic [WIDTH-1:0] alt_analog_io_in,
    input wire ppo_pkg::ppo_analog_s alt_analog_io_out [WIDTH],
    input wire logic [WIDTH-1:0] pad_in,
    input wire ppo_pkg::ppo_pad_s pad [WIDTH],
    input wire ppo_pkg::ppo_analog_s pad_analog [WIDTH]
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        a_dir_ovr: assert property (
            ovr[i].dir_ovr_en |-> pad[i].drive_en == ovr[i].dir_ovr_val)
            else $error("drive enable override lost");
        a_val_ovr: assert property (
            ovr[i].value_ovr_en |-> pad[i].drive_val == ovr[i].value_ovr_val)
            else $error("value override lost");
        a_pull_ovr: assert property (
            ovr[i].pullup_ovr_en |-> pad[i].pullup_en == ovr[i].pullup_ovr_val)
            else $error("pull-up override lost");
        a_pull_off: assert property (
            global_pullup_off && !ovr[i].pullup_ovr_en |-> !pad[i].pullup_en)
            else $error("pull-up on while globally off");
        a_pull_drive: assert property (
            !ovr[i].pullup_ovr_en && !ovr[i].dir_ovr_en && pad[i].drive_en
            |-> !pad[i].pullup_en) else $error("pull-up on an output");
        a_sleep_clamp: assert property (
            !ovr[i].in_enable_ovr_en && sleep && !eint[i].irq_en
            |-> !pad[i].input_en && !alt_digital_in[i]) else $error("input not clamped");
        a_irq_escape: assert property (
            !ovr[i].in_enable_ovr_en && (!sleep || eint[i].irq_en) |-> pad[i].input_en)
            else $error("input wrongly clamped");
        a_in_ovr: assert property (
            ovr[i].in_enable_ovr_en |-> pad[i].input_en == ovr[i].in_enable_ovr_val)
            else $error("input enable override lost");
        a_analog_path: assert property (
            pad_analog[i] == alt_analog_io_out[i] && alt_analog_io_in[i] == pad_in[i])
            else $error("analog path not straight");
        a_toggle_ovr: assert property (
            ovr[i].toggle_ovr_en && !ovr[i].value_ovr_en && !reg_wr ##1 !ovr[i].value_ovr_en
            |-> pad[i].drive_val != $past(pad[i].drive_val)) else $error("toggle missed");
    end
endmodule
bind ppo_port ppo_port_checker #(.WIDTH(WIDTH)) u_chk (.clock(clock), .rst(rst),
    .reg_wr(reg_wr), .sleep(sleep), .global_pullup_off(global_pullup_off),
    .ovr(ovr), .eint(eint), .alt_digital_in(alt_digital_in),
    .alt_analog_io_in(alt_analog_io_in), .alt_analog_io_out(alt_analog_io_out),
    .pad_in(pad_in), .pad(pad), .pad_analog(pad_analog));
`default_nettype wire

//--- dv/tb_top.sv
// tb_top: self-checking bench of ppo_port with a peripheral model
// assumes: 4-pin port, all inputs driven after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned W = 4;
    logic clock = 0;
    logic rst = 1;
    logic [2:0] reg_addr = '0;
    logic [W-1:0] reg_wdata = '0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic sleep = 0;
    logic off = 0;
    logic [W-1:0] pad_in = '0;
    logic [W-1:0] rdata, din, ev, ain, din_q, acc, d, q;
    ppo_pkg::ppo_ovr_s req [W];
    ppo_pkg::ppo_ovr_s ovr [W];
    ppo_pkg::ppo_eint_s eint [W];
    ppo_pkg::ppo_analog_s aout [W];
    ppo_pkg::ppo_analog_s pan [W];
    ppo_pkg::ppo_pad_s pad [W];
    ppo_pkg::ppo_pad_s e_pad;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    ppo_periph #(.WIDTH(W)) u_per (.clock(clock), .rst(rst), .req(req), .din(din),
        .ovr(ovr), .aout(aout), .din_q(din_q));
    ppo_port #(.WIDTH(W)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .sleep(sleep), .global_pullup_off(off), .ovr(ovr), .eint(eint),
        .alt_digital_in(din), .alt_analog_io_in(ain), .alt_analog_io_out(aout),
        .ext_edge_event(ev), .pad_in(pad_in), .pad(pad), .pad_analog(pan));
    initial begin
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [W-1:0] v);
        @(posedge clock);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic rd(logic [2:0] a, logic [W-1:0] e);
        @(posedge clock);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        #1;
        chk("rdata", e, rdata);
    endtask
    // expected pad controls of one pin
    function automatic ppo_pkg::ppo_pad_s expf(ppo_pkg::ppo_ovr_s o, logic dr, logic ou,
        logic of, logic s, logic irq);
        return {o.value_ovr_en ? o.value_ovr_val : ou, o.dir_ovr_en ? o.dir_ovr_val : dr,
            o.pullup_ovr_en ? o.pullup_ovr_val : ({dr, ou, of} == 3'h2),
            o.in_enable_ovr_en ? o.in_enable_ovr_val : !(s && !irq)};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < W; i++) begin
            req[i] = '0;
            eint[i] = '0;
        end
        void'($urandom(61249));
        repeat (10) @(posedge clock);
        rst <= 0;
        rd(ppo_pkg::REG_DIR, '0);
        rd(ppo_pkg::REG_OUT, '0);
        $display("test reset done");
        repeat (40) begin
            d = W'($urandom);
            q = W'($urandom);
            @(posedge clock);
            off <= 1'($urandom);
            sleep <= 1'($urandom);
            pad_in <= W'($urandom);
            for (int i = 0; i < W; i++) begin
                req[i] <= ppo_pkg::ppo_ovr_s'(9'($urandom) & 9'h1fb);
                eint[i] <= ppo_pkg::ppo_eint_s'(3'($urandom));
            end
            wr(ppo_pkg::REG_DIR, d);
            wr(ppo_pkg::REG_OUT, q);
            #1;
            for (int i = 0; i < W; i++) begin
                e_pad = expf(ovr[i], d[i], q[i], off, sleep, eint[i].irq_en);
                chk("pad", e_pad, pad[i]);
                chk("alt_in", pad_in[i] & e_pad.input_en, din[i]);
                chk("aio_out", aout[i], pan[i]);
            end
        end
        $display("test random pads done");
        for (int i = 0; i < W; i++) begin
            req[i] <= '0;
        end
        sleep <= 0;
        off <= 0;
        wr(ppo_pkg::REG_OUT, 4'h5);
        wr(ppo_pkg::REG_PIN_IN, 4'hf);
        rd(ppo_pkg::REG_OUT, 4'ha);
        @(posedge clock);
        req[0].toggle_ovr_en <= 1;
        @(posedge clock);
        req[0].toggle_ovr_en <= 0;
        rd(ppo_pkg::REG_OUT, 4'hb);
        $display("test toggle done");
        d = W'($urandom);
        pad_in <= d;
        repeat (3) @(posedge clock);
        rd(ppo_pkg::REG_PIN_IN, d);
        chk("sync", d, din_q);
        chk("aio", d, ain);
        rd(3'h6, '0);
        rd(3'h7, '0);
        $display("test input done");
        // pins 0..3 sense low level, any change, falling, rising
        for (int i = 0; i < W; i++) begin
            eint[i] <= ppo_pkg::ppo_eint_s'({1'b0, 2'(i)});
        end
        pad_in <= 4'hf;
        repeat (3) @(posedge clock);
        sleep <= 1;
        acc = '0;
        repeat (4) begin
            @(posedge clock);
            #1;
            acc |= ev;
        end
        chk("sleep_edge", 4'h6, acc);
        sleep <= 0;
        acc = '0;
        repeat (5) begin
            @(posedge clock);
            #1;
            acc |= ev;
        end
        chk("wake", 4'ha, acc);
        $display("test wake done");
        wr(ppo_pkg::REG_DIR, '0);
        wr(ppo_pkg::REG_OUT, 4'hf);
        #1;
        chk("pull", 1'b1, pad[0].pullup_en);
        wr(ppo_pkg::REG_DRIVE_STATE, 4'hf);
        rd(ppo_pkg::REG_DRIVE_STATE, '0);
        rd(ppo_pkg::REG_PULL_STATE, 4'hf);
        rd(ppo_pkg::REG_IN_ENABLE_STATE, 4'hf);
        rst <= 1;
        @(posedge clock);
        #1;
        for (int i = 0; i < W; i++) begin
            chk("rst_pull", 1'b0, pad[i].pullup_en);
        end
        rst <= 0;
        rd(ppo_pkg::REG_OUT, '0);
        $display("test mid reset done");
        results();
    end
endmodule
`default_nettype wire
